//--- hw/upf_fifo.sv
/*
  flip-flop fifo with valid/ready on both sides, indexed storage.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module upf_fifo #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic [AW:0] level
);
  import upf_pkg::*;
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);
  wire push = wr_valid && wr_ready;
  wire pop = rd_valid && rd_ready;
  assign wr_ready = cnt_reg != FULL_CNT;
  assign rd_valid = cnt_reg != '0;
  assign rd_data = mem[rp_reg];
  assign level = cnt_reg;

  always_ff @(posedge clk) begin
    if (push)
      mem[wp_reg] <= wr_data;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push)
        wp_reg <= (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
      if (pop)
        rp_reg <= (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- hw/upf_port.sv
/*
  asynchronous 8-bit parallel fifo port: receive and transmit fifos,
  strobe edge handling, flags, bus drive, send-immediate/wakeup and power enable.
  assumes strobes are synchronous to clk; usb engine sits on the usb-side ports.
*/
`timescale 1ns/1ps
module upf_port (
  input wire logic clk,
  input wire logic sys_rst,
  input upf_pkg::upf_pins_in_t pins_in,
  output logic [7:0] fifo_data_bus_out,
  output logic fifo_data_bus_oe,
  output logic rx_avail_n,
  output logic tx_space_n,
  output logic ext_power_enable_n,
  input upf_pkg::upf_byte_t usb_rx_in,
  output logic usb_rx_ready,
  output upf_pkg::upf_byte_t usb_tx_out,
  input wire logic usb_tx_ready,
  input wire logic usb_configured,
  input wire logic usb_suspended,
  input wire logic remote_wakeup_en,
  input wire logic bulk_in_req,
  output logic flush_pulse,
  output logic resume_req
);
  import upf_pkg::*;

  logic rd_n_reg, wr_reg, si_n_reg;
  logic flush_pend_reg;
  upf_state_t state_reg, state_next;
  logic rxq_valid, txq_ready, txq_valid;
  logic [7:0] rxq_data, txq_data;
  logic rx_ready_w;
  logic [UPF_RX_AW:0] rxq_level;
  logic [UPF_TX_AW:0] txq_level;

  // edges are found against the previous sample; inputs are already synchronous
  wire rd_rise = !rd_n_reg && pins_in.rd_n;
  wire wr_fall = wr_reg && !pins_in.wr;
  wire si_fall = si_n_reg && !pins_in.si_wu_n;
  wire rx_pop = rd_rise && rxq_valid;
  wire tx_push = wr_fall;
  wire rd_active = !pins_in.rd_n && rxq_valid;
  wire tx_pop = usb_tx_ready && usb_tx_out.valid;
  // the engine hands over a byte on valid && usb_rx_ready, so the fifo pushes on that too
  wire rx_push = usb_rx_in.valid && usb_rx_ready && rx_ready_w;
  // flags follow the fill level after this edge, so they never blink between bytes
  wire rx_keeps = (rxq_level > 10'h001) || (rxq_valid && !rx_pop) || rx_push;
  wire rx_fill_last = rxq_level == (UPF_RX_DEPTH_CNT - 10'h001) && rx_push && !rx_pop;
  wire tx_fill_last = txq_level == (UPF_TX_DEPTH_CNT - 8'h01) && tx_push && !tx_pop;
  wire tx_full_next = (!txq_ready && !tx_pop) || tx_fill_last;

  upf_fifo #(.DEPTH(UPF_RX_DEPTH), .AW(UPF_RX_AW)) u_rxq (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_valid(usb_rx_in.valid && usb_rx_ready),
    .wr_data(usb_rx_in.data),
    .wr_ready(rx_ready_w),
    .rd_valid(rxq_valid),
    .rd_data(rxq_data),
    .rd_ready(rx_pop),
    .level(rxq_level)
  );

  // a write while full is dropped by the fifo; the controller must respect tx_space_n
  upf_fifo #(.DEPTH(UPF_TX_DEPTH), .AW(UPF_TX_AW)) u_txq (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_valid(tx_push),
    .wr_data(pins_in.data_in),
    .wr_ready(txq_ready),
    .rd_valid(txq_valid),
    .rd_data(txq_data),
    .rd_ready(tx_pop),
    .level(txq_level)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UPF_UNCONF: if (usb_configured) state_next = UPF_ACTIVE;
      UPF_ACTIVE: begin
        if (!usb_configured)
          state_next = UPF_UNCONF;
        else if (usb_suspended)
          state_next = UPF_SUSPEND;
      end
      UPF_SUSPEND: begin
        if (!usb_configured)
          state_next = UPF_UNCONF;
        else if (!usb_suspended)
          state_next = UPF_ACTIVE;
      end
      default: state_next = UPF_UNCONF;
    endcase
  end

  // a held-high strobe gives no falling edge, so an unused pin never flushes or wakes
  wire flush_set = si_fall && state_reg == UPF_ACTIVE;
  wire wake_set = si_fall && state_reg == UPF_SUSPEND && remote_wakeup_en;
  wire flush_fire = (flush_pend_reg || flush_set) && bulk_in_req;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_n_reg <= 1'b1;
      wr_reg <= 1'b0;
      si_n_reg <= 1'b1;
      state_reg <= UPF_UNCONF;
      flush_pend_reg <= 1'b0;
      flush_pulse <= 1'b0;
      resume_req <= 1'b0;
      fifo_data_bus_out <= UPF_DATA_RST;
      fifo_data_bus_oe <= 1'b0;
      rx_avail_n <= 1'b1;
      tx_space_n <= 1'b1;
      ext_power_enable_n <= 1'b1;
      usb_rx_ready <= 1'b0;
      usb_tx_out <= '0;
    end else begin
      rd_n_reg <= pins_in.rd_n;
      wr_reg <= pins_in.wr;
      si_n_reg <= pins_in.si_wu_n;
      state_reg <= state_next;
      // a new strobe in the firing cycle keeps the request pending
      flush_pend_reg <= flush_set ? (flush_pend_reg || !bulk_in_req) : (flush_pend_reg && !bulk_in_req);
      flush_pulse <= flush_fire;
      resume_req <= wake_set;
      fifo_data_bus_oe <= rd_active;
      fifo_data_bus_out <= rd_active ? rxq_data : UPF_DATA_RST;
      rx_avail_n <= !rx_keeps;
      tx_space_n <= tx_full_next;
      ext_power_enable_n <= state_next != UPF_ACTIVE;
      // ready drops with the last free slot, so the engine can never overrun the fifo
      usb_rx_ready <= (rx_ready_w || rx_pop) && !rx_fill_last;
      usb_tx_out.valid <= txq_valid && !tx_pop;
      usb_tx_out.data <= txq_data;
    end
  end
endmodule

//--- inc/upf_pkg.sv
/*
  constants, state encoding and carrier types for the usb parallel fifo port.
  assumes a single 40 MHz clock and strobes synchronous to it.
*/
// Functional notes
// - rx_avail_n is low while the receive fifo holds at least one byte and high when it is empty.
// - tx_space_n is low while the transmit fifo has room; the controller then writes by raising and lowering wr.
// - each falling edge of wr appends the byte on fifo_data_bus to the transmit fifo, unless that fifo is full.
// - while the read strobe is low the head receive byte is driven onto the bus, otherwise the bus is released.
// - each rising edge of the read strobe drops the presented byte and advances to the next one, if any.
// - the bus is eight two-way lines, bit 0 to bit 7, driven by the device on reads and sampled on writes.
// - when configured and not suspended, a low strobe on send-immediately/wakeup flushes buffered data on the next bulk in request.
// - when suspended with remote wakeup enabled, a low strobe on send-immediately/wakeup requests a resume.
// - ext_power_enable_n goes low once configured and high again while suspended.
package upf_pkg;
  localparam int UPF_DATA_W = 8;
  localparam int UPF_RX_DEPTH = 384;
  localparam int UPF_TX_DEPTH = 128;
  localparam int UPF_RX_AW = 9;
  localparam int UPF_TX_AW = 7;
  localparam logic [7:0] UPF_DATA_RST = 8'h00;
  localparam logic [UPF_RX_AW:0] UPF_RX_DEPTH_CNT = 10'h180;
  localparam logic [UPF_TX_AW:0] UPF_TX_DEPTH_CNT = 8'h80;

  typedef enum logic [1:0] {
    UPF_UNCONF = 2'b00,
    UPF_ACTIVE = 2'b01,
    UPF_SUSPEND = 2'b11
  } upf_state_t;

  // one byte with its handshake, used on both usb-facing streams
  typedef struct packed {
    logic valid;
    logic [UPF_DATA_W-1:0] data;
  } upf_byte_t;

  // parallel pin group seen by the device
  typedef struct packed {
    logic rd_n;
    logic wr;
    logic si_wu_n;
    logic [UPF_DATA_W-1:0] data_in;
  } upf_pins_in_t;
endpackage

//--- test/upf_ctl_model.sv
/* controller on the parallel side. assumes clk and the port's outputs */
`timescale 1ns/1ps
module upf_ctl_model (
  input wire logic clk,
  input wire logic fifo_data_bus_oe,
  input wire logic [7:0] fifo_data_bus_out,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  output upf_pkg::upf_pins_in_t pins_in
);
  import upf_pkg::*;
  logic rd_n = 1'b1;
  logic wr = 1'b0;
  logic si_n = 1'b1;
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  // pull-ups hold a released bus high
  assign pins_in = {rd_n, wr, si_n, fifo_data_bus_oe ? fifo_data_bus_out : (drv ? wd : 8'hff)};
  task automatic rd(output logic [7:0] b, input bit ign);
    b = 8'hff;
    if (rx_avail_n && !ign) return;
    @(posedge clk) rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    b = pins_in.data_in;
    rd_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr_byte(input logic [7:0] b, input bit ign);
    if (tx_space_n && !ign) return;
    @(posedge clk);
    wr <= 1'b1;
    wd <= b;
    drv <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk) drv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic si();
    @(posedge clk) si_n <= 1'b0;
    @(posedge clk) si_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule

//--- test/upf_port_bench.sv
/* bench for upf_port. usb side driven here, parallel side by upf_ctl_model */
`timescale 1ns/1ps
module upf_port_bench;
  import upf_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  upf_pins_in_t pins_in;
  upf_byte_t usb_rx_in = '0;
  upf_byte_t usb_tx_out;
  logic [7:0] fifo_data_bus_out, b;
  logic fifo_data_bus_oe, rx_avail_n, tx_space_n, ext_power_enable_n, usb_rx_ready, flush_pulse, resume_req;
  logic usb_tx_ready = 1'b0, usb_configured = 1'b0, usb_suspended = 1'b0;
  logic remote_wakeup_en = 1'b0, bulk_in_req = 1'b0;
  int error_cnt = 0, total_checks = 0, nf = 0, nr = 0, cnt, n;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    nf <= nf + flush_pulse;
    nr <= nr + resume_req;
  end
  upf_port dut_u (.*);
  upf_ctl_model ctl_u (.*);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, s);
      error_cnt++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_rx();
    chk("txe", 8'h00, tx_space_n);
    chk("rxrdy", 8'h01, usb_rx_ready);
    usb_rx_in <= {1'b1, 8'ha5};
    @(posedge clk);
    while (!usb_rx_ready) @(posedge clk);
    usb_rx_in <= {1'b1, 8'h3c};
    @(posedge clk);
    while (!usb_rx_ready) @(posedge clk);
    usb_rx_in <= '0;
    repeat (3) @(posedge clk);
    chk("rxf", 8'h00, rx_avail_n);
    ctl_u.rd(b, 1'b0);
    chk("byte0", 8'ha5, b);
    ctl_u.rd(b, 1'b0);
    chk("byte1", 8'h3c, b);
    chk("rxf", 8'h01, rx_avail_n);
    // a read strobe on an empty fifo must leave the bus to its pull-ups and pop nothing
    ctl_u.rd(b, 1'b1);
    chk("noread", 8'hff, b);
    chk("rxf", 8'h01, rx_avail_n);
    $display("t_rx end");
  endtask
  task automatic t_tx();
    // the usb side stalls, so the transmit fifo fills
    for (cnt = 0; !tx_space_n && cnt < 140; cnt++) ctl_u.wr_byte(cnt[7:0], 1'b0);
    chk("txe", 8'h01, tx_space_n);
    ctl_u.wr_byte(8'hee, 1'b1);
    usb_tx_ready <= 1'b1;
    n = 0;
    repeat (cnt * 3 + 20) begin
      @(posedge clk);
      if (usb_tx_out.valid && usb_tx_ready) begin
        chk("txbyte", n[7:0], usb_tx_out.data);
        n++;
      end
    end
    chk("txcount", cnt[7:0], n[7:0]);
    $display("t_tx end");
  endtask
  task automatic t_si();
    chk("idle", 8'h00, nf[7:0] | nr[7:0]);
    usb_configured <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pen", 8'h00, ext_power_enable_n);
    // a bulk request with the strobe held high must not flush
    bulk_in_req <= 1'b1;
    @(posedge clk) bulk_in_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk("noflush", 8'h00, nf[7:0]);
    ctl_u.si();
    bulk_in_req <= 1'b1;
    @(posedge clk) bulk_in_req <= 1'b0;
    repeat (4) @(posedge clk);
    chk("flush", 8'h01, nf[7:0]);
    usb_suspended <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pen", 8'h01, ext_power_enable_n);
    // without remote wakeup a strobe in suspend asks for nothing
    ctl_u.si();
    repeat (3) @(posedge clk);
    chk("nowake", 8'h00, nr[7:0]);
    remote_wakeup_en <= 1'b1;
    @(posedge clk);
    ctl_u.si();
    repeat (3) @(posedge clk);
    chk("resume", 8'h01, nr[7:0]);
    $display("t_si end");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_rx();
    t_tx();
    t_si();
    tally_and_finish();
  end
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind upf_port upf_port_props chk_u (.*);

//--- test/upf_port_props.sv
/* port checker for upf_port. assumes it is bound to the port, one clock */
`timescale 1ns/1ps
module upf_port_props (
  input wire logic clk,
  input wire logic sys_rst,
  input upf_pkg::upf_pins_in_t pins_in,
  input wire logic [7:0] fifo_data_bus_out,
  input wire logic fifo_data_bus_oe,
  input wire logic rx_avail_n,
  input wire logic ext_power_enable_n,
  input wire logic usb_configured,
  input wire logic usb_suspended,
  input wire logic bulk_in_req,
  input wire logic flush_pulse,
  input wire logic resume_req
);
  import upf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rd_drive: assert property (!pins_in.rd_n && !rx_avail_n |=> fifo_data_bus_oe)
    else $error("bus not driven");
  a_rd_release: assert property (pins_in.rd_n |=> !fifo_data_bus_oe)
    else $error("bus not released");
  a_bus_idle: assert property (!fifo_data_bus_oe |-> fifo_data_bus_out == 8'h00)
    else $error("idle bus value");
  // the flag may only rise as a popped byte leaves the bus
  a_rx_empty: assert property ($rose(rx_avail_n) |-> $past(fifo_data_bus_oe))
    else $error("flag rose without pop");
  a_pwr_on: assert property (usb_configured && !usb_suspended |=> !ext_power_enable_n)
    else $error("power not enabled");
  a_pwr_off: assert property (usb_suspended |=> ext_power_enable_n)
    else $error("power not removed");
  a_flush_cause: assert property (flush_pulse |-> $past(bulk_in_req) || $past(bulk_in_req, 2))
    else $error("flush without request");
  a_wake_cause: assert property (resume_req |-> usb_suspended &&
    (!$past(pins_in.si_wu_n) || !$past(pins_in.si_wu_n, 2))) else $error("resume without strobe");
  cover property (fifo_data_bus_oe);
  cover property (flush_pulse);
  cover property (resume_req);
endmodule
